// File: dv/lpmc_ctrl_tb.sv
// Self-checking bench for the low-power mode controller.
// Assumes lpmc_pkg is compiled first; the bench drives every port itself.
module lpmc_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import lpmc_pkg::*;

	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic core_clk, rst, enter, fast_rc_req, vref_en, lp_run_req, flag_clr;
	logic [1:0] volt_range, act_range;
	logic [15:0] ev;
	logic [2:0] log_addr;
	logic [5:0] osc_run_en, osc_en;
	lpmc_mode_t mode;
	lpmc_state_t state;
	logic cpu_clk_en, reg_lp, reg_off, core_pwr, core_rst, ram_retain, ms_low, wake, sby_flag;
	logic [15:0] freq_cap, log_data;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;

	lpmc_ctrl dut (.CORE_CLK_I(core_clk), .RST_I(rst), .VOLT_RANGE_I(volt_range), .LP_RUN_REQ_I(lp_run_req),
		.ENTER_I(enter), .MODE_I(mode), .OSC_RUN_EN_I(osc_run_en), .FAST_RC_REQ_I(fast_rc_req),
		.PERIPH_IRQ_I(ev[13]), .EVT_GPIO_I(ev[0]), .EVT_SVD_I(ev[1]), .EVT_COMP1_I(ev[2]),
		.EVT_COMP2_I(ev[3]), .VREF_EN_I(vref_en), .EVT_RTC_ALARM_A_I(ev[4]), .EVT_RTC_ALARM_B_I(ev[5]),
		.EVT_RTC_TAMPER_I(ev[6]), .EVT_RTC_TSTAMP_I(ev[7]), .EVT_RTC_WAKE_TIMER_I(ev[8]),
		.EVT_PERIPH_WAKE_I({ev[9], 4'h0}), .WAKE_PIN_I({ev[15], ev[12], ev[14]}),
		.EXTERNAL_RESET_PIN_N_I(~ev[11]), .WATCHDOG_RST_I(ev[10]), .STANDBY_FLAG_CLR_I(flag_clr),
		.LOG_RD_ADDR_I(log_addr), .POWER_STATE_O(state), .CPU_CLK_EN_O(cpu_clk_en),
		.REG_LOW_POWER_O(reg_lp), .REG_OFF_O(reg_off), .CORE_PWR_O(core_pwr), .CORE_RST_O(core_rst),
		.RAM_RETAIN_O(ram_retain), .MULTISPEED_OSC_LOW_O(ms_low), .OSC_EN_O(osc_en),
		.FREQ_CAP_KHZ_O(freq_cap), .ACTIVE_RANGE_O(act_range), .WAKE_O(wake),
		.STANDBY_FLAG_O(sby_flag), .LOG_RD_DATA_O(log_data));

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		if (failures == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Inputs move 1 ns after the edge, so outputs are settled when read
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic enter_mode(input lpmc_mode_t m);
		mode = m;
		enter = 1'b1;
		step(1);
		enter = 1'b0;
	endtask

	// Pulse one wake source and time the return to run
	task automatic go(input lpmc_mode_t m, input lpmc_state_t st, input int idx, input int lim, input logic exp_w);
		int n;
		if (state === ST_RUN)
			enter_mode(m);
		chk("mode_state", 16'(state), 16'(st));
		chk("cpu_clk", 16'(cpu_clk_en), 16'h0000);
		ev[idx] = 1'b1;
		step(1);
		ev = '0;
		if (exp_w)
			chk("core_rst", 16'(core_rst), 16'(lim == 1200));
		n = 1;
		while (wake !== 1'b1 && n < lim + 3)
		begin
			step(1);
			n++;
		end
		chk("woke", 16'(n <= lim), 16'(exp_w));
		chk("after_state", 16'(state), 16'(exp_w ? ST_RUN : st));
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic ranges();
		logic [15:0] caps [3] = '{16'h7D00, 16'h3E80, 16'h1068};
		for (int r = 1; r <= 3; r++)
		begin
			volt_range = 2'(r);
			step(2);
			volt_range = 2'h0;
			chk("range", 16'(act_range), 16'(r));
			chk("freq_cap", freq_cap, caps[r-1]);
		end
		enter_mode(lpmc_mode_t'(3'h6));
		chk("illegal_mode", 16'(state), 16'(ST_RUN));
	endtask

	task automatic low_power_run();
		lp_run_req = 1'b1;
		step(2);
		chk("lp_state", 16'(state), 16'(ST_LP_RUN));
		chk("ms_low", 16'(ms_low), 16'h0001);
		chk("reg_lp", 16'(reg_lp), 16'h0001);
		chk("lp_freq", freq_cap, 16'h0083);
		chk("ms_on", 16'(osc_en[OSC_MULTISPEED]), 16'h0001);
		lp_run_req = 1'b0;
		step(2);
		chk("run_state", 16'(state), 16'(ST_RUN));
	endtask

	task automatic sleeps();
		go(MODE_SLEEP, ST_SLEEP, 13, 2, 1'b1);
		go(MODE_SLEEP, ST_SLEEP, 0, 2, 1'b1);
		enter_mode(MODE_LP_SLEEP);
		chk("lps_reg", 16'(reg_lp), 16'h0001);
		go(MODE_LP_SLEEP, ST_LP_SLEEP, 13, 2, 1'b1);
		chk("reg_on", 16'(reg_lp), 16'h0000);
		// Log holds irq, gpio, irq causes in slots 0..2
		log_addr = 3'h1;
		step(1);
		chk("log_gpio", log_data, 16'h0001);
		log_addr = 3'h2;
		step(1);
		chk("log_irq", log_data, 16'h1000);
	endtask

	task automatic stops();
		int rtc_src [8] = '{0, 1, 4, 5, 6, 7, 8, 9};
		int nortc_src [5] = '{0, 1, 2, 3, 9};
		enter_mode(MODE_STOP_RTC);
		chk("stop_osc", 16'(osc_en), 16'h0030);
		chk("stop_reg", 16'(reg_lp), 16'h0001);
		chk("stop_ram", 16'(ram_retain), 16'h0001);
		fast_rc_req = 1'b1;
		step(1);
		chk("fast_rc", 16'(osc_en), 16'h0034);
		fast_rc_req = 1'b0;
		go(MODE_STOP_RTC, ST_STOP_RTC, 2, 70, 1'b0);
		vref_en = 1'b1;
		go(MODE_STOP_RTC, ST_STOP_RTC, 3, 70, 1'b1);
		vref_en = 1'b0;
		foreach (rtc_src[i])
			go(MODE_STOP_RTC, ST_STOP_RTC, rtc_src[i], 70, 1'b1);
		enter_mode(MODE_STOP_NORTC);
		chk("nortc_osc", 16'(osc_en), 16'h0000);
		chk("nortc_ram", 16'(ram_retain), 16'h0001);
		// Clock-domain events have no path out of this mode
		go(MODE_STOP_NORTC, ST_STOP_NORTC, 4, 70, 1'b0);
		vref_en = 1'b1;
		foreach (nortc_src[i])
			go(MODE_STOP_NORTC, ST_STOP_NORTC, nortc_src[i], 70, 1'b1);
		vref_en = 1'b0;
	endtask

	task automatic standbys();
		int rtc_src [8] = '{4, 5, 6, 7, 8, 10, 11, 12};
		volt_range = 2'h1;
		step(2);
		volt_range = 2'h0;
		enter_mode(MODE_STBY_RTC);
		chk("sby_reg_off", 16'(reg_off), 16'h0001);
		chk("sby_core", 16'(core_pwr), 16'h0000);
		chk("sby_osc", 16'(osc_en), 16'h0030);
		chk("sby_ram", 16'(ram_retain), 16'h0000);
		go(MODE_STBY_RTC, ST_STBY_RTC, 0, 1200, 1'b0);
		foreach (rtc_src[i])
			go(MODE_STBY_RTC, ST_STBY_RTC, rtc_src[i], 1200, 1'b1);
		chk("sby_flag", 16'(sby_flag), 16'h0001);
		chk("sby_range", 16'(act_range), 16'h0002);
		flag_clr = 1'b1;
		step(1);
		flag_clr = 1'b0;
		step(1);
		chk("flag_clr", 16'(sby_flag), 16'h0000);
		enter_mode(MODE_STBY_NORTC);
		chk("nortc_sby_osc", 16'(osc_en), 16'h0000);
		go(MODE_STBY_NORTC, ST_STBY_NORTC, 4, 1200, 1'b0);
		go(MODE_STBY_NORTC, ST_STBY_NORTC, 12, 1200, 1'b1);
		go(MODE_STBY_NORTC, ST_STBY_NORTC, 11, 1200, 1'b1);
		go(MODE_STBY_NORTC, ST_STBY_NORTC, 14, 1200, 1'b1);
		go(MODE_STBY_NORTC, ST_STBY_NORTC, 15, 1200, 1'b1);
	endtask

	// ****************************************
	// Main sequence and hang guard
	// ****************************************
	// Ceiling covers about a dozen standby exits plus margin
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			failures++;
			results();
		end
	end

	initial
	begin
		rst = 1'b1;
		enter = 1'b0;
		fast_rc_req = 1'b0;
		vref_en = 1'b0;
		lp_run_req = 1'b0;
		flag_clr = 1'b0;
		volt_range = 2'h0;
		ev = '0;
		log_addr = 3'h0;
		osc_run_en = 6'h3F;
		mode = MODE_SLEEP;
		step(20);
		chk("rst_state", 16'(state), 16'(ST_RUN));
		chk("rst_osc", 16'(osc_en), 16'h0002);
		chk("rst_freq", freq_cap, 16'h3E80);
		chk("rst_range", 16'(act_range), 16'h0002);
		rst = 1'b0;
		step(1);
		ranges();
		low_power_run();
		sleeps();
		stops();
		standbys();
		results();
	end
endmodule

// File: verilog/lpmc_ctrl.sv
// Power-mode sequencer: voltage range, sleep, stop and standby control.
// Assumes all inputs synchronous to CORE_CLK_I and software driving the mode pins.

// Functional notes
// - Three voltage ranges cap the CPU at 32 MHz, 16 MHz and 4.2 MHz.
// - Seven reduced-power modes: sleep, LP run, LP sleep, two stops, two standbys.
// - Sleep halts only the CPU clock; any interrupt or event wakes it, comparator events only with the reference on.
// - LP run uses multispeed oscillator low setting, at most 131 kHz, regulator low.
// - LP sleep is sleep with the regulator held in low-power state.
// - Wake from LP sleep returns to run with the regulator on.
// - Stop with clock gates core clocks, fast oscillators off, slow ones run.
// - Both stop modes keep RAM and register contents.
// - In stop a wake-capable peripheral may request the fast internal oscillator.
// - Any wake source of the active stop mode wakes it within 3.5 us.
// - Stop with clock wakes on GPIO, detector, clock events and peripheral wakes.
// - Comparator events wake stop only while the reference voltage is on.
// - Stop without clock stops all clocks and every oscillator but a requested fast RC.
// - Stop without clock still wakes on GPIO, detector, comparators, peripheral wakes.
// - Standby with clock powers off regulator and core, fast oscillators off.
// - Standby loses RAM and registers except the standby circuitry.
// - Standby exits within 60 us on reset or wake pins; with clock also on watchdog or clock events.
module lpmc_ctrl
(
	input wire logic CORE_CLK_I,
	input wire logic RST_I,
	input wire logic [1:0] VOLT_RANGE_I,
	input wire logic LP_RUN_REQ_I,
	input wire logic ENTER_I,
	input wire lpmc_pkg::lpmc_mode_t MODE_I,
	input wire logic [lpmc_pkg::OSC_W-1:0] OSC_RUN_EN_I,
	input wire logic FAST_RC_REQ_I,
	input wire logic PERIPH_IRQ_I,
	input wire logic EVT_GPIO_I,
	input wire logic EVT_SVD_I,
	input wire logic EVT_COMP1_I,
	input wire logic EVT_COMP2_I,
	input wire logic VREF_EN_I,
	input wire logic EVT_RTC_ALARM_A_I,
	input wire logic EVT_RTC_ALARM_B_I,
	input wire logic EVT_RTC_TAMPER_I,
	input wire logic EVT_RTC_TSTAMP_I,
	input wire logic EVT_RTC_WAKE_TIMER_I,
	input wire logic [4:0] EVT_PERIPH_WAKE_I,
	input wire logic [2:0] WAKE_PIN_I,
	input wire logic EXTERNAL_RESET_PIN_N_I,
	input wire logic WATCHDOG_RST_I,
	input wire logic STANDBY_FLAG_CLR_I,
	input wire logic [lpmc_pkg::LOG_AW-1:0] LOG_RD_ADDR_I,
	output lpmc_pkg::lpmc_state_t POWER_STATE_O,
	output logic CPU_CLK_EN_O,
	output logic REG_LOW_POWER_O,
	output logic REG_OFF_O,
	output logic CORE_PWR_O,
	output logic CORE_RST_O,
	output logic RAM_RETAIN_O,
	output logic MULTISPEED_OSC_LOW_O,
	output logic [lpmc_pkg::OSC_W-1:0] OSC_EN_O,
	output logic [15:0] FREQ_CAP_KHZ_O,
	output logic [1:0] ACTIVE_RANGE_O,
	output logic WAKE_O,
	output logic STANDBY_FLAG_O,
	output logic [lpmc_pkg::CAUSE_W-1:0] LOG_RD_DATA_O
);
	import lpmc_pkg::*;

	// ********************************
	// State
	// ********************************
	typedef struct packed {
		lpmc_state_t state;
		logic [10:0] cnt;
		logic [1:0] range;
		logic [2:0] pin_prev;
		logic stby_flag;
		logic [LOG_AW-1:0] log_ptr;
		logic log_we;
		logic [CAUSE_W-1:0] log_data;
		logic wake_pulse;
		logic [OSC_W-1:0] osc_en;
		logic cpu_clk_en;
		logic reg_lp;
		logic reg_off;
		logic core_pwr;
		logic core_rst;
		logic retain;
		logic msi_low;
		logic [15:0] freq_cap;
	} lpmc_regs_t;

	lpmc_regs_t r;
	lpmc_regs_t next_r;
	logic [CAUSE_W-1:0] cause;
	logic in_stop;
	logic in_stby;

	function automatic logic mask_hit(input logic [CAUSE_W-1:0] c, input logic [CAUSE_W-1:0] m);
		mask_hit = |(c & m);
	endfunction

	function automatic logic [15:0] range_cap(input logic [1:0] rng);
		unique case (rng)
			RANGE_1: range_cap = FREQ_RANGE_1;
			RANGE_3: range_cap = FREQ_RANGE_3;
			default: range_cap = FREQ_RANGE_2;
		endcase
	endfunction

	// ********************************
	// Wake cause collection
	// ********************************
	always_comb
	begin
		cause = '0;
		cause[CAUSE_GPIO] = EVT_GPIO_I;
		cause[CAUSE_SVD] = EVT_SVD_I;
		// Comparators count only with the reference on
		cause[CAUSE_COMP] = VREF_EN_I & (EVT_COMP1_I | EVT_COMP2_I);
		cause[CAUSE_ALARM_A] = EVT_RTC_ALARM_A_I;
		cause[CAUSE_ALARM_B] = EVT_RTC_ALARM_B_I;
		cause[CAUSE_TAMPER] = EVT_RTC_TAMPER_I;
		cause[CAUSE_TSTAMP] = EVT_RTC_TSTAMP_I;
		cause[CAUSE_WAKE_TIMER] = EVT_RTC_WAKE_TIMER_I;
		cause[CAUSE_PERIPH] = |EVT_PERIPH_WAKE_I;
		// Wake pins act on the rising edge only
		cause[CAUSE_WAKE_PIN] = |(WAKE_PIN_I & ~r.pin_prev);
		cause[CAUSE_EXT_RESET] = ~EXTERNAL_RESET_PIN_N_I;
		cause[CAUSE_WATCHDOG] = WATCHDOG_RST_I;
		cause[CAUSE_IRQ] = PERIPH_IRQ_I;
	end

	assign in_stop = (r.state == ST_STOP_RTC) || (r.state == ST_STOP_NORTC);
	assign in_stby = (r.state == ST_STBY_RTC) || (r.state == ST_STBY_NORTC);

	// ********************************
	// Next-state logic
	// ********************************
	always_comb
	begin
		next_r = r;
		next_r.wake_pulse = 1'b0;
		next_r.log_we = 1'b0;
		next_r.pin_prev = WAKE_PIN_I;
		if (r.log_we)
		begin
			next_r.log_ptr = r.log_ptr + 3'h1;
		end
		if (STANDBY_FLAG_CLR_I)
		begin
			next_r.stby_flag = 1'b0;
		end
		unique case (r.state)
			ST_RUN, ST_LP_RUN:
			begin
				if (r.state == ST_RUN && VOLT_RANGE_I != 2'h0)
				begin
					next_r.range = VOLT_RANGE_I;
				end
				next_r.state = LP_RUN_REQ_I ? ST_LP_RUN : ST_RUN;
				if (ENTER_I)
				begin
					case (MODE_I)
						MODE_SLEEP: next_r.state = ST_SLEEP;
						MODE_LP_SLEEP: next_r.state = ST_LP_SLEEP;
						MODE_STOP_RTC: next_r.state = ST_STOP_RTC;
						MODE_STOP_NORTC: next_r.state = ST_STOP_NORTC;
						MODE_STBY_RTC: next_r.state = ST_STBY_RTC;
						MODE_STBY_NORTC: next_r.state = ST_STBY_NORTC;
						default: next_r.state = r.state;
					endcase
				end
			end
			ST_SLEEP, ST_LP_SLEEP:
			begin
				if (mask_hit(cause, CAUSE_SLEEP_MASK))
				begin
					next_r.state = ST_RUN;
					next_r.wake_pulse = 1'b1;
					next_r.log_we = 1'b1;
					next_r.log_data = cause & CAUSE_SLEEP_MASK;
				end
			end
			ST_STOP_RTC, ST_STOP_NORTC:
			begin
				if (mask_hit(cause, (r.state == ST_STOP_RTC) ? CAUSE_STOP_RTC_MASK : CAUSE_STOP_NORTC_MASK))
				begin
					next_r.state = ST_STOP_EXIT;
					next_r.cnt = '0;
					next_r.log_we = 1'b1;
					next_r.log_data = cause & ((r.state == ST_STOP_RTC) ? CAUSE_STOP_RTC_MASK : CAUSE_STOP_NORTC_MASK);
				end
			end
			ST_STOP_EXIT:
			begin
				// Oscillator restart window, bounded by the stop wake time
				next_r.cnt = r.cnt + 11'h001;
				if (r.cnt == STOP_LAST)
				begin
					next_r.state = ST_RUN;
					next_r.wake_pulse = 1'b1;
				end
			end
			ST_STBY_RTC, ST_STBY_NORTC:
			begin
				if (mask_hit(cause, (r.state == ST_STBY_RTC) ? CAUSE_STBY_RTC_MASK : CAUSE_STBY_NORTC_MASK))
				begin
					next_r.state = ST_STBY_EXIT;
					next_r.cnt = '0;
					next_r.log_we = 1'b1;
					next_r.log_data = cause & ((r.state == ST_STBY_RTC) ? CAUSE_STBY_RTC_MASK : CAUSE_STBY_NORTC_MASK);
				end
			end
			ST_STBY_EXIT:
			begin
				next_r.cnt = r.cnt + 11'h001;
				// Core state is gone; restart from defaults as after reset
				next_r.range = RANGE_RESET;
				if (r.cnt == STBY_LAST)
				begin
					next_r.state = ST_RUN;
					next_r.wake_pulse = 1'b1;
					next_r.stby_flag = 1'b1;
				end
			end
		endcase

		// Registered power controls, derived from the coming state
		next_r.cpu_clk_en = 1'b0;
		next_r.reg_lp = 1'b0;
		next_r.reg_off = 1'b0;
		next_r.core_pwr = 1'b1;
		next_r.core_rst = 1'b0;
		next_r.retain = 1'b1;
		next_r.msi_low = 1'b0;
		next_r.osc_en = OSC_RUN_EN_I;
		next_r.freq_cap = range_cap(next_r.range);
		unique case (next_r.state)
			ST_RUN:
			begin
				next_r.cpu_clk_en = 1'b1;
			end
			ST_SLEEP:
			begin
				// Peripherals keep their clocks
				next_r.cpu_clk_en = 1'b0;
			end
			ST_LP_RUN, ST_LP_SLEEP:
			begin
				next_r.cpu_clk_en = (next_r.state == ST_LP_RUN);
				next_r.reg_lp = 1'b1;
				next_r.msi_low = 1'b1;
				next_r.freq_cap = FREQ_LP_RUN;
				next_r.osc_en = (OSC_RUN_EN_I & OSC_LP_MASK) | OSC_RESET;
			end
			ST_STOP_RTC, ST_STOP_NORTC:
			begin
				next_r.reg_lp = 1'b1;
				next_r.freq_cap = FREQ_STOPPED;
				next_r.osc_en = (next_r.state == ST_STOP_RTC) ? (OSC_RUN_EN_I & OSC_SLOW_MASK) : OSC_NONE;
				next_r.osc_en[OSC_FAST_RC] = FAST_RC_REQ_I;
			end
			ST_STOP_EXIT:
			begin
				next_r.freq_cap = FREQ_STOPPED;
			end
			ST_STBY_RTC, ST_STBY_NORTC:
			begin
				next_r.reg_off = 1'b1;
				next_r.core_pwr = 1'b0;
				next_r.retain = 1'b0;
				next_r.freq_cap = FREQ_STOPPED;
				next_r.osc_en = (next_r.state == ST_STBY_RTC) ? (OSC_RUN_EN_I & OSC_SLOW_MASK) : OSC_NONE;
			end
			ST_STBY_EXIT:
			begin
				next_r.core_rst = 1'b1;
				next_r.retain = 1'b0;
				next_r.freq_cap = FREQ_STOPPED;
				next_r.osc_en = OSC_RESET;
			end
		endcase
		// A set in the same cycle beats software's clear
		if (r.state == ST_STBY_EXIT && r.cnt == STBY_LAST)
		begin
			next_r.stby_flag = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			r <= '{state: ST_RUN, cnt: 11'h000, range: RANGE_RESET, pin_prev: 3'h7, stby_flag: 1'b0,
				log_ptr: 3'h0, log_we: 1'b0, log_data: 16'h0000, wake_pulse: 1'b0, osc_en: OSC_RESET,
				cpu_clk_en: 1'b1, reg_lp: 1'b0, reg_off: 1'b0, core_pwr: 1'b1, core_rst: 1'b0,
				retain: 1'b1, msi_low: 1'b0, freq_cap: FREQ_RANGE_2};
		end
		else
		begin
			r <= next_r;
		end
	end

	// ********************************
	// Retained wake log
	// ********************************
	lpmc_wake_log u_log
	(
		.clk_i(CORE_CLK_I),
		.we_i(r.log_we),
		.wr_addr_i(r.log_ptr),
		.wr_data_i(r.log_data),
		.rd_addr_i(LOG_RD_ADDR_I),
		.rd_data_o(LOG_RD_DATA_O)
	);

	assign POWER_STATE_O = r.state;
	assign CPU_CLK_EN_O = r.cpu_clk_en;
	assign REG_LOW_POWER_O = r.reg_lp;
	assign REG_OFF_O = r.reg_off;
	assign CORE_PWR_O = r.core_pwr;
	assign CORE_RST_O = r.core_rst;
	assign RAM_RETAIN_O = r.retain;
	assign MULTISPEED_OSC_LOW_O = r.msi_low;
	assign OSC_EN_O = r.osc_en;
	assign FREQ_CAP_KHZ_O = r.freq_cap;
	assign ACTIVE_RANGE_O = r.range;
	assign WAKE_O = r.wake_pulse;
	assign STANDBY_FLAG_O = r.stby_flag;

	// ********************************
	// Assertions
	// ********************************
	localparam int STOP_WAKE_BOUND = int'(STOP_WAKE_CYC);

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RST_I);

	sequence s_stop_trigger;
		in_stop && mask_hit(cause, (r.state == ST_STOP_RTC) ? CAUSE_STOP_RTC_MASK : CAUSE_STOP_NORTC_MASK);
	endsequence

	sequence s_stby_done;
		(r.state == ST_STBY_EXIT) && (r.cnt == STBY_LAST);
	endsequence

	AST_RANGE_CAP: assert property ((r.state == ST_RUN && r.range == RANGE_3) |-> FREQ_CAP_KHZ_O == FREQ_RANGE_3)
		else $error("range 3 cap wrong");
	AST_RANGE1_CAP: assert property ((r.state == ST_RUN && r.range == RANGE_1) |-> FREQ_CAP_KHZ_O == FREQ_RANGE_1)
		else $error("range 1 cap wrong");
	AST_MODE_ENTRY: assert property ((r.state == ST_RUN && ENTER_I && MODE_I == MODE_STOP_NORTC) |=> r.state == ST_STOP_NORTC)
		else $error("stop entry missed");
	AST_SLEEP_WAKE: assert property ((r.state == ST_SLEEP && PERIPH_IRQ_I) |=> (WAKE_O && CPU_CLK_EN_O && CORE_PWR_O))
		else $error("sleep did not wake");
	AST_LP_RUN: assert property ((r.state == ST_LP_RUN) |-> (MULTISPEED_OSC_LOW_O && REG_LOW_POWER_O && OSC_EN_O[OSC_MULTISPEED] && FREQ_CAP_KHZ_O == FREQ_LP_RUN))
		else $error("low-power run setup wrong");
	AST_LP_SLEEP: assert property ((r.state == ST_LP_SLEEP) |-> (REG_LOW_POWER_O && !CPU_CLK_EN_O))
		else $error("low-power sleep setup wrong");
	AST_LP_SLEEP_WAKE: assert property ((r.state == ST_LP_SLEEP && mask_hit(cause, CAUSE_SLEEP_MASK)) |=> (r.state == ST_RUN && !REG_LOW_POWER_O && WAKE_O))
		else $error("low-power sleep wake wrong");
	AST_STOP_RTC_OSC: assert property ((r.state == ST_STOP_RTC) |-> (!OSC_EN_O[OSC_PLL] && !OSC_EN_O[OSC_MULTISPEED] && !OSC_EN_O[OSC_FAST_XTAL] && REG_LOW_POWER_O))
		else $error("stop oscillators left on");
	AST_STOP_RETAIN: assert property ((in_stop || r.state == ST_STOP_EXIT) |-> RAM_RETAIN_O && CORE_PWR_O)
		else $error("stop lost retention");
	AST_FAST_RC_REQ: assert property ((in_stop && FAST_RC_REQ_I) ##1 in_stop |-> OSC_EN_O[OSC_FAST_RC])
		else $error("fast oscillator request ignored");
	AST_STOP_WAKE_TIME: assert property (s_stop_trigger |-> ##[1:STOP_WAKE_BOUND] WAKE_O)
		else $error("stop wake too slow");
	AST_STOP_RTC_SRC: assert property ((r.state == ST_STOP_RTC && EVT_RTC_TAMPER_I) |=> r.state == ST_STOP_EXIT)
		else $error("clock event did not wake stop");
	AST_COMP_GATE: assert property ((in_stop && !VREF_EN_I && cause == '0) ##0 (EVT_COMP1_I || EVT_COMP2_I) |=> $stable(r.state))
		else $error("comparator woke without reference");
	AST_STOP_NORTC_OSC: assert property ((r.state == ST_STOP_NORTC && !$past(FAST_RC_REQ_I)) |-> OSC_EN_O == OSC_NONE)
		else $error("oscillator on in stop without clock");
	AST_STOP_NORTC_SRC: assert property ((r.state == ST_STOP_NORTC && (EVT_GPIO_I || EVT_PERIPH_WAKE_I != 5'h00)) |=> r.state == ST_STOP_EXIT)
		else $error("stop without clock missed wake");
	AST_STBY_OFF: assert property ((r.state == ST_STBY_RTC) |-> (REG_OFF_O && !CORE_PWR_O && (OSC_EN_O & ~OSC_SLOW_MASK) == OSC_NONE))
		else $error("standby power not off");
	AST_STBY_LOSS: assert property ((in_stby || r.state == ST_STBY_EXIT) |-> !RAM_RETAIN_O)
		else $error("standby claims retention");
	AST_STBY_CNT: assert property ((r.state == ST_STBY_EXIT) |-> r.cnt <= STBY_LAST)
		else $error("standby exit overran");
	AST_STBY_DONE: assert property (s_stby_done |=> (r.state == ST_RUN && WAKE_O && STANDBY_FLAG_O))
		else $error("standby exit end wrong");
	AST_STBY_RESET_SEQ: assert property ((r.state == ST_STBY_EXIT) |-> ##1 (CORE_RST_O || (r.state == ST_RUN && ACTIVE_RANGE_O == RANGE_RESET)))
		else $error("standby exit not a reset sequence");

endmodule

// File: verilog/lpmc_pkg.sv
// Shared constants and types for the low-power mode controller.
// Assumes one 20 MHz core clock and a synchronous active-high reset.
package lpmc_pkg;

	// ********************************
	// Modes and states
	// ********************************
	typedef enum logic [3:0] {
		ST_RUN, ST_LP_RUN, ST_SLEEP, ST_LP_SLEEP, ST_STOP_RTC, ST_STOP_NORTC,
		ST_STOP_EXIT, ST_STBY_RTC, ST_STBY_NORTC, ST_STBY_EXIT
	} lpmc_state_t;

	// Codes 6 and 7 are illegal and ignored
	typedef enum logic [2:0] {
		MODE_SLEEP, MODE_LP_SLEEP, MODE_STOP_RTC, MODE_STOP_NORTC, MODE_STBY_RTC, MODE_STBY_NORTC
	} lpmc_mode_t;

	// ********************************
	// Voltage ranges and CPU ceilings (kHz)
	// ********************************
	localparam logic [1:0] RANGE_1 = 2'h1;
	localparam logic [1:0] RANGE_2 = 2'h2;
	localparam logic [1:0] RANGE_3 = 2'h3;
	localparam logic [1:0] RANGE_RESET = RANGE_2;
	localparam logic [15:0] FREQ_RANGE_1 = 16'h7D00;
	localparam logic [15:0] FREQ_RANGE_2 = 16'h3E80;
	localparam logic [15:0] FREQ_RANGE_3 = 16'h1068;
	localparam logic [15:0] FREQ_LP_RUN = 16'h0083;
	localparam logic [15:0] FREQ_STOPPED = 16'h0000;

	// ********************************
	// Oscillator enable vector
	// ********************************
	localparam int OSC_W = 6;
	localparam int OSC_PLL = 0;
	localparam int OSC_MULTISPEED = 1;
	localparam int OSC_FAST_RC = 2;
	localparam int OSC_FAST_XTAL = 3;
	localparam int OSC_SLOW_XTAL = 4;
	localparam int OSC_SLOW_RC = 5;
	localparam logic [5:0] OSC_RESET = 6'h02;
	localparam logic [5:0] OSC_LP_MASK = 6'h3A;
	localparam logic [5:0] OSC_SLOW_MASK = 6'h30;
	localparam logic [5:0] OSC_NONE = 6'h00;

	// ********************************
	// Wake cause vector
	// ********************************
	localparam int CAUSE_W = 16;
	localparam int CAUSE_GPIO = 0;
	localparam int CAUSE_SVD = 1;
	localparam int CAUSE_COMP = 2;
	localparam int CAUSE_ALARM_A = 3;
	localparam int CAUSE_ALARM_B = 4;
	localparam int CAUSE_TAMPER = 5;
	localparam int CAUSE_TSTAMP = 6;
	localparam int CAUSE_WAKE_TIMER = 7;
	localparam int CAUSE_PERIPH = 8;
	localparam int CAUSE_WAKE_PIN = 9;
	localparam int CAUSE_EXT_RESET = 10;
	localparam int CAUSE_WATCHDOG = 11;
	localparam int CAUSE_IRQ = 12;
	localparam logic [15:0] CAUSE_SLEEP_MASK = 16'h11FF;
	localparam logic [15:0] CAUSE_STOP_RTC_MASK = 16'h01FF;
	localparam logic [15:0] CAUSE_STOP_NORTC_MASK = 16'h0107;
	localparam logic [15:0] CAUSE_STBY_RTC_MASK = 16'h0EF8;
	localparam logic [15:0] CAUSE_STBY_NORTC_MASK = 16'h0600;
	localparam logic [15:0] CAUSE_RTC_MASK = 16'h00F8;

	// ********************************
	// Wake log and timing
	// ********************************
	localparam int LOG_DEPTH = 8;
	localparam int LOG_AW = 3;
	localparam int CLK_PERIOD_NS = 50;
	localparam int STOP_WAKE_NS = 3500;
	localparam int STBY_EXIT_NS = 60000;
	localparam logic [10:0] STOP_WAKE_CYC = 11'(STOP_WAKE_NS / CLK_PERIOD_NS);
	localparam logic [10:0] STBY_EXIT_CYC = 11'(STBY_EXIT_NS / CLK_PERIOD_NS);
	localparam logic [10:0] STOP_LAST = STOP_WAKE_CYC - 11'h002;
	localparam logic [10:0] STBY_LAST = STBY_EXIT_CYC - 11'h002;

endpackage

// File: verilog/lpmc_wake_log.sv
// Small retained memory of recent wake causes.
// Assumes it sits in the always-powered standby domain.
module lpmc_wake_log
(
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [lpmc_pkg::LOG_AW-1:0] wr_addr_i,
	input wire logic [lpmc_pkg::CAUSE_W-1:0] wr_data_i,
	input wire logic [lpmc_pkg::LOG_AW-1:0] rd_addr_i,
	output logic [lpmc_pkg::CAUSE_W-1:0] rd_data_o
);
	import lpmc_pkg::*;

	// No reset on the array; unwritten words read undefined
	logic [CAUSE_W-1:0] mem [LOG_DEPTH];

	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end

endmodule
